// file: rtl/status_queue_pkg.sv
// Package with constants for the status and message queue block
package status_queue_pkg;
   // Queue capacity in bytes and address width
   localparam int QUEUE_BYTES = 10240;
   localparam int QUEUE_AW = 14;
   // Status byte bit positions
   localparam int SB_DEV0_BIT = 0;
   localparam int SB_DEV1_BIT = 1;
   localparam int SB_REPLY_BIT = 4;
   localparam int SB_STDEV_BIT = 5;
   localparam int SB_SUMMARY_BIT = 6;
   // Standard event bit positions
   localparam int SE_OPC_BIT = 0;
   localparam int SE_QUERY_BIT = 2;
   localparam int SE_DEVICE_BIT = 3;
   localparam int SE_EXEC_BIT = 4;
   localparam int SE_SYNTAX_BIT = 5;
   localparam int SE_POWER_BIT = 7;
   // Masks of the implemented bits
   localparam logic [7:0] SB_USED_MASK = 8'h73;
   localparam logic [7:0] SE_USED_MASK = 8'hBD;
   // Reset values
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] SE_RESET = 8'h80;
endpackage

// file: rtl/byte_ram.sv
// Byte memory with separate write and read ports and registered read data
`timescale 1ns/10ps
module byte_ram #(
   parameter int DEPTH = 10240,
   parameter int AW = 14
) (
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   // Storage array
   logic [7:0] mem [DEPTH];

   initial begin
      if (DEPTH > (1 << AW)) begin
         $error("byte_ram depth does not fit address width");
      end
   end

   // Write and registered read
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// file: rtl/byte_queue.sv
// Byte queue of fixed capacity built on the byte memory
`timescale 1ns/10ps
module byte_queue #(
   parameter int DEPTH = 10240,
   parameter int AW = 14
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   output logic in_ready,
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data,
   output logic empty,
   output logic full
);
   // Pointers and fill level
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic stage_valid_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire fetch = (count_reg != '0) && (!stage_valid_reg || pop);
   wire [AW-1:0] depth_last = AW'(DEPTH - 1);
   // Slot of the staged byte, re-read so its data stand until taken
   wire [AW-1:0] stage_addr = (rd_ptr_reg == '0) ? depth_last
      : rd_ptr_reg - 1'b1;
   wire [AW-1:0] rd_addr_sel = fetch ? rd_ptr_reg : stage_addr;
   // Bytes held, the staged one included, so capacity is DEPTH
   wire [AW:0] level = count_reg + (AW+1)'(stage_valid_reg);

   // Entries still in memory plus the staged one
   assign full = (level == (AW+1)'(DEPTH));
   assign in_ready = !full && !flush;
   assign out_valid = stage_valid_reg;
   assign empty = !stage_valid_reg && (count_reg == '0);

   byte_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
      .clk_sys(clk_sys),
      .wr_en(push),
      .wr_addr(wr_ptr_reg),
      .wr_data(in_data),
      .rd_addr(rd_addr_sel),
      .rd_data(out_data)
   );

   // Pointer, count and output stage control
   always_ff @(posedge clk_sys) begin
      if (rst || flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         stage_valid_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == depth_last) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (fetch) begin
            rd_ptr_reg <= (rd_ptr_reg == depth_last) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(fetch);
         if (fetch) begin
            stage_valid_reg <= 1'b1;
         end else if (pop) begin
            stage_valid_reg <= 1'b0;
         end
      end
   end
endmodule

// file: rtl/status_reporting_queues.sv
// Message queues and status reporting of the remote interface
//
// Notes on behaviour
// RULE_01: Reply queue 10 KB; overflow flags query error, empties.
// RULE_02: New message with unread replies: discard, query error.
// RULE_03: Reply queue emptied on reset, clear, query error.
// RULE_04: Command bytes buffered 10 KB, delivered in order.
// RULE_05: Full command buffer holds bus handshake waiting.
// RULE_06: Serial link bytes beyond capacity are refused.
// RULE_07: Controller keeps each command below 10 KB.
// RULE_08: Enabled status bit sets summary bit 6, request.
// RULE_09: Request fires on enabled bit rising edge.
// RULE_10: Status byte is eight bits, returned on poll.
// RULE_11: Request bit cleared when serial poll reads it.
// RULE_12: Summary bit follows sources, shown by status query.
// RULE_13: Bit 4 shows replies queued; 7,3,2 unused.
// RULE_14: Bits 1 and 0 summarise device event registers.
// RULE_15: Request mask gates status bits one by one.
// RULE_16: Masked standard events drive status bit 5.
// RULE_17: Standard events cleared by clear, query, power-up.
// RULE_18: Power bit set at power-up; 6,1 unused.
// RULE_19: Syntax fault sets bit 5.
// RULE_20: Cannot-run fault sets bit 4.
// RULE_21: Device fault sets bit 3.
// RULE_22: Query fault sets bit 2, empties reply queue.
// RULE_23: Operation complete sets bit 0.
// RULE_24: Unused bits read zero, never summarised.
`timescale 1ns/10ps
module status_reporting_queues #(
   parameter int DEPTH = status_queue_pkg::QUEUE_BYTES,
   parameter int AW = status_queue_pkg::QUEUE_AW
) (
   input wire logic clk_sys,
   input wire logic rst,
   // Link side command bytes
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_is_serial,
   output logic cmd_ready,
   output logic cmd_refused,
   // Parser side command bytes
   output logic exec_valid,
   output logic [7:0] exec_data,
   input wire logic exec_ready,
   // Start of a new incoming message
   input wire logic msg_start,
   // Reply bytes from the parser
   input wire logic reply_valid,
   input wire logic [7:0] reply_data,
   output logic reply_ready,
   // Reply bytes to the link
   output logic out_valid,
   output logic [7:0] out_data,
   input wire logic out_ready,
   input wire logic read_empty_req,
   input wire logic reply_lost,
   // Device clear
   input wire logic dev_clear,
   // Parser events
   input wire logic ev_syntax,
   input wire logic ev_cannot_run,
   input wire logic ev_device,
   input wire logic ev_opc_done,
   input wire logic ev_power_up,
   input wire logic cls_cmd,
   input wire logic esr_query,
   // Device event register summaries
   input wire logic [7:0] dev_event_zero,
   input wire logic [7:0] dev_event_one,
   // Mask writes
   input wire logic request_mask_wr,
   input wire logic std_event_mask_wr,
   input wire logic [7:0] mask_wdata,
   // Serial poll
   input wire logic serial_poll,
   // Register views
   output logic [7:0] poll_status_byte,
   output logic [7:0] poll_read_data,
   output logic [7:0] request_mask,
   output logic [7:0] std_event_mask,
   output logic [7:0] std_event_flags,
   output logic [7:0] esr_read_data,
   output logic service_request
);
   // Mask and flag registers
   logic [7:0] request_mask_reg;
   logic [7:0] std_event_mask_reg;
   logic [7:0] std_event_flags_reg;
   logic [7:0] std_event_flags_next;
   logic request_reg;
   logic [7:0] prev_enabled_reg;
   logic [7:0] poll_reg;
   logic [7:0] esr_read_reg;

   // Queue status wires
   logic in_full;
   logic reply_empty;
   logic reply_full;

   initial begin
      if (DEPTH < 2 || DEPTH > (1 << AW)) begin
         $error("status_reporting_queues depth does not fit");
      end
   end

   // Query errors from every source
   wire reply_overflow = reply_valid && reply_full; // RULE_01
   wire stale_reply = msg_start && !reply_empty; // RULE_02
   wire query_fault = reply_overflow || stale_reply // RULE_22
      || read_empty_req || reply_lost;
   wire reply_flush = dev_clear || query_fault; // RULE_03

   // Input command buffer; full holds handshake off
   byte_queue #(.DEPTH(DEPTH), .AW(AW)) u_in_queue ( // RULE_04
      .clk_sys(clk_sys),
      .rst(rst),
      .flush(dev_clear),
      .in_valid(cmd_valid),
      .in_data(cmd_data),
      .in_ready(cmd_ready), // RULE_05
      .out_valid(exec_valid),
      .out_ready(exec_ready),
      .out_data(exec_data),
      .empty(),
      .full(in_full)
   );

   // Serial bytes offered while full are dropped, not stalled
   assign cmd_refused = cmd_valid && cmd_is_serial && in_full; // RULE_06

   // Reply queue, overflowing byte causes a flush
   byte_queue #(.DEPTH(DEPTH), .AW(AW)) u_out_queue (
      .clk_sys(clk_sys),
      .rst(rst),
      .flush(reply_flush), // RULE_03
      .in_valid(reply_valid),
      .in_data(reply_data),
      .in_ready(),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data),
      .empty(reply_empty),
      .full(reply_full)
   );
   // Reply side never stalls; overflow is an error instead
   assign reply_ready = 1'b1; // RULE_01

   // Status byte summary bits
   wire dev0_sum = |dev_event_zero; // RULE_14
   wire dev1_sum = |dev_event_one; // RULE_14
   wire std_event_summary = // RULE_16
      |(std_event_flags_reg & std_event_mask_reg & status_queue_pkg::SE_USED_MASK);
   wire reply_pending = !reply_empty; // RULE_13
   wire [7:0] sb_sources = {1'b0, 1'b0, std_event_summary, reply_pending,
      1'b0, 1'b0, dev1_sum, dev0_sum}; // RULE_24
   wire [7:0] sb_enabled = sb_sources & request_mask_reg // RULE_15
      & status_queue_pkg::SB_USED_MASK;
   wire master_summary = |sb_enabled; // RULE_08 RULE_12
   wire rise = |(sb_enabled & ~prev_enabled_reg); // RULE_09
   // Status query view shows the summary in bit 6
   assign poll_status_byte = sb_sources // RULE_10
      | (8'(master_summary) << status_queue_pkg::SB_SUMMARY_BIT);

   // Event setting combined with clearing, sets win
   wire se_clear = cls_cmd || esr_query; // RULE_17
   wire [7:0] se_set = (8'(ev_opc_done) << status_queue_pkg::SE_OPC_BIT) // RULE_23
      | (8'(query_fault) << status_queue_pkg::SE_QUERY_BIT) // RULE_22
      | (8'(ev_device) << status_queue_pkg::SE_DEVICE_BIT) // RULE_21
      | (8'(ev_cannot_run) << status_queue_pkg::SE_EXEC_BIT) // RULE_20
      | (8'(ev_syntax) << status_queue_pkg::SE_SYNTAX_BIT) // RULE_19
      | (8'(ev_power_up) << status_queue_pkg::SE_POWER_BIT); // RULE_18
   always_comb begin
      std_event_flags_next = se_clear ? 8'h00 : std_event_flags_reg;
      std_event_flags_next = (std_event_flags_next | se_set)
         & status_queue_pkg::SE_USED_MASK; // RULE_24
   end

   // Mask registers written by the parser
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         request_mask_reg <= status_queue_pkg::MASK_RESET;
         std_event_mask_reg <= status_queue_pkg::MASK_RESET;
      end else begin
         if (request_mask_wr) begin
            request_mask_reg <= mask_wdata; // RULE_15
         end
         if (std_event_mask_wr) begin
            std_event_mask_reg <= mask_wdata;
         end
      end
   end

   // Standard event flags; power flag set out of reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         std_event_flags_reg <= status_queue_pkg::SE_RESET; // RULE_17 RULE_18
         esr_read_reg <= 8'h00;
      end else begin
         std_event_flags_reg <= std_event_flags_next;
         if (esr_query) begin
            esr_read_reg <= std_event_flags_reg;
         end
      end
   end

   // Request bit: set on rising enabled bit, cleared by poll
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         request_reg <= 1'b0;
         prev_enabled_reg <= 8'h00;
         poll_reg <= 8'h00;
      end else begin
         prev_enabled_reg <= sb_enabled;
         if (rise) begin
            request_reg <= 1'b1; // RULE_09
         end else if (serial_poll) begin
            request_reg <= 1'b0; // RULE_11
         end
         if (serial_poll) begin
            poll_reg <= sb_sources // RULE_10
               | (8'(request_reg) << status_queue_pkg::SB_SUMMARY_BIT);
         end
      end
   end

   assign request_mask = request_mask_reg;
   assign std_event_mask = std_event_mask_reg;
   assign std_event_flags = std_event_flags_reg;
   assign esr_read_data = esr_read_reg;
   assign poll_read_data = poll_reg; // RULE_10
   assign service_request = request_reg; // RULE_08

   // Checks
   // Overflowing reply byte empties the queue and flags it
   a_overflow_flush: assert property (@(posedge clk_sys) // RULE_01
      disable iff (rst) reply_overflow
      |=> reply_empty && std_event_flags_reg[2])
      else $error("overflow did not flush queue");
   // Message start over unread replies discards them
   a_stale_flush: assert property (@(posedge clk_sys) // RULE_02
      disable iff (rst) stale_reply && !se_clear
      |=> std_event_flags_reg[2] && reply_empty)
      else $error("stale reply not discarded");
   // Device clear leaves no reply byte offered
   a_clear_flush: assert property (@(posedge clk_sys) // RULE_03
      disable iff (rst) dev_clear
      |=> !out_valid)
      else $error("device clear left replies");
   // Full command buffer never shows ready
   a_full_wait: assert property (@(posedge clk_sys) // RULE_05
      disable iff (rst) in_full
      |-> !cmd_ready)
      else $error("ready while buffer full");
   // Enabled rising status bit raises the request
   a_rise_request: assert property (@(posedge clk_sys) // RULE_09
      disable iff (rst) rise
      |=> service_request)
      else $error("request not raised");
   // Poll clears the request and reports it in bit 6
   a_poll_clear: assert property (@(posedge clk_sys) // RULE_11
      disable iff (rst) serial_poll && !rise && request_reg
      |=> !service_request && poll_reg[6])
      else $error("poll did not clear request");
   // Summary bit is the masked or of the other bits
   a_summary_bit: assert property (@(posedge clk_sys) // RULE_08
      disable iff (rst) poll_status_byte[6]
      == |(poll_status_byte[5:0] & request_mask_reg[5:0]))
      else $error("summary bit mismatch");
   // Clear with no event in the same cycle empties the flags
   a_event_clear: assert property (@(posedge clk_sys) // RULE_17
      disable iff (rst) se_clear && se_set == 8'h00
      |=> std_event_flags_reg == 8'h00)
      else $error("event flags not cleared");
   // Unused bits never read as one
   a_unused_zero: assert property (@(posedge clk_sys) // RULE_24
      disable iff (rst) (std_event_flags_reg & 8'h42) == 8'h00
      && (poll_status_byte & 8'h8C) == 8'h00)
      else $error("unused bit set");
   // Waiting reply byte and its data stand until taken
   a_reply_hold: assert property (@(posedge clk_sys) // RULE_03
      disable iff (rst) out_valid && !out_ready && !reply_flush
      |=> out_valid && $stable(out_data))
      else $error("reply byte changed before taken");
   // Waiting command byte and its data stand until taken
   a_cmd_hold: assert property (@(posedge clk_sys) // RULE_04
      disable iff (rst) exec_valid && !exec_ready && !dev_clear
      |=> exec_valid && $stable(exec_data))
      else $error("command byte changed before taken");
   // A refused serial byte is never taken as well
   a_serial_refuse: assert property (@(posedge clk_sys) // RULE_06
      disable iff (rst) cmd_refused
      |-> !cmd_ready)
      else $error("refused byte also accepted");
   // Reply byte on offer shows as pending
   a_reply_flag: assert property (@(posedge clk_sys) // RULE_13
      disable iff (rst) out_valid
      |-> poll_status_byte[4])
      else $error("pending bit low with reply offered");
   // Bits 1 and 0 follow the device event registers
   a_dev_summary: assert property (@(posedge clk_sys) // RULE_14
      disable iff (rst) poll_status_byte[1:0]
      == {|dev_event_one, |dev_event_zero})
      else $error("device summary mismatch");
   // No enabled source means no summary
   a_mask_gate: assert property (@(posedge clk_sys) // RULE_15
      disable iff (rst) (poll_status_byte[5:0] & request_mask_reg[5:0])
      == 6'h00 |-> !poll_status_byte[6])
      else $error("summary without enabled source");
   // Bit 5 is the masked or of the standard events
   a_std_summary: assert property (@(posedge clk_sys) // RULE_16
      disable iff (rst) poll_status_byte[5]
      == |(std_event_flags_reg & std_event_mask_reg))
      else $error("standard event summary mismatch");
   // Power event sets bit 7
   a_power_set: assert property (@(posedge clk_sys) // RULE_18
      disable iff (rst) ev_power_up
      |=> std_event_flags_reg[7])
      else $error("power flag not set");
   // Syntax fault sets bit 5
   a_syntax_set: assert property (@(posedge clk_sys) // RULE_19
      disable iff (rst) ev_syntax
      |=> std_event_flags_reg[5])
      else $error("syntax flag not set");
   // Cannot-run fault sets bit 4
   a_exec_set: assert property (@(posedge clk_sys) // RULE_20
      disable iff (rst) ev_cannot_run
      |=> std_event_flags_reg[4])
      else $error("cannot run flag not set");
   // Device fault sets bit 3
   a_device_set: assert property (@(posedge clk_sys) // RULE_21
      disable iff (rst) ev_device
      |=> std_event_flags_reg[3])
      else $error("device flag not set");
   // Every query fault flags bit 2 and withdraws the replies
   a_query_set: assert property (@(posedge clk_sys) // RULE_22
      disable iff (rst) query_fault
      |=> std_event_flags_reg[2] && !out_valid)
      else $error("query fault not handled");
   // Operation complete sets bit 0
   a_opc_set: assert property (@(posedge clk_sys) // RULE_23
      disable iff (rst) ev_opc_done
      |=> std_event_flags_reg[0])
      else $error("complete flag not set");
   // Event query returns the flags as they stood
   a_esr_capture: assert property (@(posedge clk_sys) // RULE_17
      disable iff (rst) esr_query
      |=> esr_read_reg == $past(std_event_flags_reg))
      else $error("event query data wrong");
   // Serial poll returns the status sources
   a_poll_capture: assert property (@(posedge clk_sys) // RULE_10
      disable iff (rst) serial_poll
      |=> poll_reg[5:0] == $past(sb_sources[5:0]))
      else $error("poll data wrong");
   // Request stands until a serial poll
   a_request_hold: assert property (@(posedge clk_sys) // RULE_11
      disable iff (rst) service_request && !serial_poll
      |=> service_request)
      else $error("request dropped without poll");
   // Request rises only from an enabled edge
   a_request_edge: assert property (@(posedge clk_sys) // RULE_09
      disable iff (rst) !rise && !service_request
      |=> !service_request)
      else $error("request without edge");
endmodule

// file: tb/remote_ctrl_model.sv
// Remote controller model that takes reply bytes from the link side
`timescale 1ns/10ps
module remote_ctrl_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic stall,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   output logic out_ready,
   output logic [7:0] last_byte
);
   // Ready follows the stall request, low while in reset
   always_ff @(posedge clk_sys) begin
      out_ready <= !rst && !stall;
   end
   // Keep the byte taken at each handshake edge
   always_ff @(posedge clk_sys) begin
      if (out_valid && out_ready) begin
         last_byte <= out_data;
      end
   end
endmodule

// file: tb/status_reporting_queues_tb_top.sv
// Self-checking bench for the status and message queue block
`timescale 1ns/10ps
module status_reporting_queues_tb_top;
   localparam int D = 16; // Short queues keep the run brief
   logic clk_sys = 1'b0, rst = 1'b1, stall = 1'b1;
   logic cmd_valid = 1'b0, cmd_is_serial = 1'b0, exec_ready = 1'b0;
   logic reply_valid = 1'b0, out_ready, cmd_ready, cmd_refused, reply_ready;
   logic exec_valid, out_valid, service_request;
   logic [7:0] cmd_data = 8'h00, reply_data = 8'h00, mask_wdata = 8'h00;
   logic [7:0] dev_event_zero = 8'h00, dev_event_one = 8'h00;
   logic [7:0] exec_data, out_data, last_byte, poll_status_byte;
   logic [7:0] poll_read_data;
   logic [7:0] request_mask, std_event_mask, std_event_flags, esr_read_data;
   logic [13:0] p = 14'h0000; // All single-cycle request pulses
   int n_errors = 0, n_checks = 0, acc, k;
   int ev_idx[5] = '{0, 1, 2, 3, 4};
   logic [7:0] ev_bit[5] = '{8'h20, 8'h10, 8'h08, 8'h01, 8'h80};
   status_reporting_queues #(.DEPTH(D), .AW(4)) dut (.clk_sys(clk_sys),
      .rst(rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
      .cmd_is_serial(cmd_is_serial), .cmd_ready(cmd_ready),
      .cmd_refused(cmd_refused), .exec_valid(exec_valid),
      .exec_data(exec_data), .exec_ready(exec_ready), .msg_start(p[7]),
      .reply_valid(reply_valid), .reply_data(reply_data),
      .reply_ready(reply_ready),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
      .read_empty_req(p[8]), .reply_lost(p[9]), .dev_clear(p[10]),
      .ev_syntax(p[0]), .ev_cannot_run(p[1]), .ev_device(p[2]),
      .ev_opc_done(p[3]), .ev_power_up(p[4]), .cls_cmd(p[5]),
      .esr_query(p[6]), .dev_event_zero(dev_event_zero),
      .dev_event_one(dev_event_one), .request_mask_wr(p[12]),
      .std_event_mask_wr(p[13]), .mask_wdata(mask_wdata),
      .serial_poll(p[11]), .poll_status_byte(poll_status_byte),
      .poll_read_data(poll_read_data),
      .request_mask(request_mask), .std_event_mask(std_event_mask),
      .std_event_flags(std_event_flags), .esr_read_data(esr_read_data),
      .service_request(service_request));
   // Far side reader of the reply queue
   remote_ctrl_model ctrl (.clk_sys(clk_sys), .rst(rst), .stall(stall),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
      .last_byte(last_byte));
   // 125 MHz clock
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   // Compare one byte result and count it
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle pulse on request line i, then let results settle
   task automatic pulse(input int i);
      @(posedge clk_sys);
      p[i] <= 1'b1;
      @(posedge clk_sys);
      p <= 14'h0000;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // Settle after a level change on the inputs
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   // Offer n command bytes holding each until taken or until 8 cycles pass without ready; count accepted ones
   task automatic push_cmd(input int n, input logic ser);
      int t;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_data <= 8'h00;
      cmd_is_serial <= ser;
      acc = 0;
      t = 0;
      while (acc < n && t < 8) begin
         @(posedge clk_sys);
         if (cmd_ready === 1'b1) begin
            acc++;
            t = 0;
            cmd_data <= 8'(acc);
         end else begin
            t++;
            if (ser) chk({7'h00, cmd_refused}, 8'h01);
         end
      end
      // Released at the edge of the last take, so no extra byte slips in
      cmd_valid <= 1'b0;
   endtask
   // Take n command bytes from the parser side, checking arrival order
   task automatic drain_cmd(input int n);
      int t;
      @(posedge clk_sys);
      exec_ready <= 1'b1;
      k = 0;
      t = 0;
      while (k < n && t < 8 * n) begin
         @(posedge clk_sys);
         t++;
         if (exec_valid === 1'b1) begin
            chk(exec_data, 8'(k));
            k++;
         end
      end
      exec_ready <= 1'b0;
      chk(8'(k), 8'(n));
   endtask
   // Push n reply bytes back to back
   task automatic push_reply(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         reply_valid <= 1'b1;
         reply_data <= base + 8'(i);
      end
      @(posedge clk_sys);
      reply_valid <= 1'b0;
      settle();
   endtask
   // Print counts and the verdict, then stop
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      settle();
      chk(std_event_flags, 8'h80);
      chk(request_mask, 8'h00);
      chk(std_event_mask, 8'h00);
      chk(poll_status_byte, 8'h00);
      // Fill the command buffer, then overrun it on both links
      push_cmd(D + 4, 1'b0);
      chk(8'(acc), 8'(D));
      push_cmd(1, 1'b1);
      chk(8'(acc), 8'h00);
      drain_cmd(D);
      push_cmd(3, 1'b0);
      drain_cmd(3);
      // Reply byte pending, then read by the controller
      push_reply(1, 8'hA5);
      chk(poll_status_byte, 8'h10);
      stall <= 1'b0;
      settle();
      chk(last_byte, 8'hA5);
      chk(poll_status_byte, 8'h00);
      stall <= 1'b1;
      // Overflow of the reply queue
      pulse(6);
      push_reply(D + 1, 8'h00);
      chk(std_event_flags, 8'h04);
      chk(poll_status_byte, 8'h00);
      chk({7'h00, reply_ready}, 8'h01);
      // New message while replies are unread
      pulse(6);
      push_reply(2, 8'h30);
      pulse(7);
      chk(std_event_flags, 8'h04);
      chk(poll_status_byte, 8'h00);
      // Device clear empties the queue without a query error
      pulse(6);
      push_reply(2, 8'h40);
      pulse(10);
      chk(poll_status_byte, 8'h00);
      chk(std_event_flags, 8'h00);
      // Read of an empty queue and lost data
      for (int i = 8; i < 10; i++) begin
         pulse(6);
         pulse(i);
         chk(std_event_flags, 8'h04);
      end
      // Each standard event source but the query error, read back and cleared by query
      for (int i = 0; i < 5; i++) begin
         pulse(6);
         pulse(ev_idx[i]);
         chk(std_event_flags, ev_bit[i]);
         pulse(6);
         chk(esr_read_data, ev_bit[i]);
         chk(std_event_flags, 8'h00);
      end
      pulse(2);
      pulse(5);
      chk(std_event_flags, 8'h00);
      // Device event summaries and masked service request
      mask_wdata <= 8'h02;
      pulse(12);
      chk(request_mask, 8'h02);
      dev_event_zero <= 8'h10;
      settle();
      chk(poll_status_byte, 8'h01);
      chk({7'h00, service_request}, 8'h00);
      dev_event_one <= 8'h80;
      settle();
      chk({7'h00, service_request}, 8'h01);
      chk(poll_status_byte, 8'h43);
      pulse(11);
      chk({7'h00, service_request}, 8'h00);
      chk(poll_status_byte, 8'h43);
      chk(poll_read_data, 8'h43);
      // Standard event summary through its mask
      pulse(0);
      chk(poll_status_byte, 8'h43);
      mask_wdata <= 8'h20;
      pulse(13);
      chk(std_event_mask, 8'h20);
      chk(poll_status_byte, 8'h63);
      report_and_stop();
   end
endmodule
